// ### shared/gcr_pkg.sv
`default_nettype none
package gcr_pkg;
    // Pin count and command codes
    localparam int unsigned GCR_NUM_PINS = 5;
    localparam logic [7:0] GCR_CMD_SET = 8'h22;
    localparam logic [7:0] GCR_CMD_READ = 8'h23;
    localparam logic [7:0] GCR_ACK_SET = 8'h62;
    localparam logic [7:0] GCR_ACK_READ = 8'h63;
    localparam logic [7:0] GCR_ERR_FLAG = 8'hc0;
    // Command port address layout: type code above, pin index below
    localparam int unsigned GCR_ADDR_TYPE_LSB = 8;
    localparam int unsigned GCR_ADDR_IDX_LSB = 0;
    // Set command write data layout
    localparam int unsigned GCR_WD_LEVEL_LSB = 0;
    localparam int unsigned GCR_WD_CFG_LSB = 8;
    localparam int unsigned GCR_WD_CFG_PRESENT = 16;
    // Read answer layout
    localparam int unsigned GCR_RD_IDX_LSB = 0;
    localparam int unsigned GCR_RD_STAT_LSB = 8;
    localparam int unsigned GCR_RD_LEVEL_LSB = 16;
    localparam int unsigned GCR_RD_CFG_LSB = 24;
    // Status byte bits
    localparam int unsigned GCR_ST_LEVEL = 0;
    localparam int unsigned GCR_ST_FALL = 1;
    localparam int unsigned GCR_ST_RISE = 2;
    // Level and configuration limits
    localparam logic [7:0] GCR_LEVEL_HIGH = 8'h64;
    localparam logic [7:0] GCR_CFG_MAX = 8'h0f;
    localparam int unsigned GCR_CFG_FUNC = 3;
    // Drive modes
    typedef enum logic [2:0] {
        GCR_DRV_HI_PULLDN = 3'h0,
        GCR_DRV_FAST_BOTH = 3'h1,
        GCR_DRV_HIZ = 3'h2,
        GCR_DRV_PULLUP_LO = 3'h3,
        GCR_DRV_SLOW_HI_Z = 3'h4,
        GCR_DRV_SLOW_BOTH = 3'h5,
        GCR_DRV_RESERVED = 3'h6,
        GCR_DRV_Z_SLOW_LO = 3'h7
    } gcr_drive_t;
    // Factory defaults, pin 4 in the top nibble
    localparam logic [19:0] GCR_CFG_RESET = 20'h31122;
    localparam logic [7:0] GCR_LEVEL_RESET = 8'h00;
    localparam int unsigned GCR_IMG_BITS = 12;
    // Timing
    localparam int unsigned GCR_CLK_HZ = 125_000_000;
    localparam int unsigned GCR_PWM_HZ = 100;
    localparam int unsigned GCR_PWM_STEPS = 100;
    localparam int unsigned GCR_SAMPLE_HZ = 32;
    // Boot sequencer states
    typedef enum logic [0:0] {
        GCR_ST_BOOT = 1'b0,
        GCR_ST_RUN = 1'b1
    } gcr_state_t;
endpackage : gcr_pkg
`default_nettype wire

// ### core/gcr_gpio.sv
// Notes on behaviour
// - Type 0x22 sets level; config optional
// - Pin index 0-4; 5-255 reserved
// - Level 0 low, 100 high, else PWM
// - Config byte 0-15: function, drive mode
// - Drive modes 000 to 011 as listed
// - Drive modes 100,101,111; 110 reserved
// - Function 1: pin follows user level
// - Function 0: default role, drive kept
// - Defaults: ATX power, ATX reset, sensor bus
// - Set answered with type 0x62 ack
// - Configuration saved in boot state
// - Type 0x23 reads one pin
// - Answer echoes the pin index
// - Bit 0 reports sampled pin level
// - Bit 1 flags falling edges since read
// - Bit 2 flags rising edges since read
// - Pins sampled at about 32 Hz
// - Byte 2 returns stored level
// - Byte 3 returns stored configuration
// - Sampled inputs are debounced
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module gcr_gpio
    import gcr_pkg::*;
#(
    parameter int unsigned PWM_STEP_CYCLES = GCR_CLK_HZ / (GCR_PWM_HZ * GCR_PWM_STEPS),
    parameter int unsigned SAMPLE_CYCLES = GCR_CLK_HZ / GCR_SAMPLE_HZ
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Command port
    input wire logic [15:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic ack_valid,
    output logic [7:0] ack_type,
    // Boot state storage
    input wire logic boot_store,
    input wire logic boot_image_valid,
    input wire logic [GCR_NUM_PINS*GCR_IMG_BITS-1:0] boot_image_in,
    output logic [GCR_NUM_PINS*GCR_IMG_BITS-1:0] boot_image_out,
    output logic boot_image_write,
    // Default pin functions
    input wire logic [GCR_NUM_PINS-1:0] alt_level,
    output logic [GCR_NUM_PINS-1:0] pin_level,
    // Pins
    input wire logic [GCR_NUM_PINS-1:0] pin_in,
    output logic [GCR_NUM_PINS-1:0] pin_out,
    output logic [GCR_NUM_PINS-1:0] pin_oe,
    output logic [GCR_NUM_PINS-1:0] pin_pull_up,
    output logic [GCR_NUM_PINS-1:0] pin_pull_down,
    output logic [GCR_NUM_PINS-1:0] pin_slow
);

    localparam int unsigned SW = (SAMPLE_CYCLES > 1) ? $clog2(SAMPLE_CYCLES) : 1;
    localparam int unsigned PW = (PWM_STEP_CYCLES > 1) ? $clog2(PWM_STEP_CYCLES) : 1;
    localparam logic [SW-1:0] SAMPLE_LAST = SW'(SAMPLE_CYCLES - 1);
    localparam logic [PW-1:0] STEP_LAST = PW'(PWM_STEP_CYCLES - 1);
    localparam logic [6:0] PHASE_LAST = 7'(GCR_PWM_STEPS - 1);
    localparam logic [7:0] PIN_LIMIT = 8'(GCR_NUM_PINS);

    // Pad drive: {oe, out, pull_up, pull_down, slow}
    function automatic logic [4:0] drive_of(input logic [2:0] mode, input logic v);
        logic [4:0] r;
        r = 5'h00;
        case (gcr_drive_t'(mode))
            GCR_DRV_HI_PULLDN: r = v ? 5'h18 : 5'h02;
            GCR_DRV_FAST_BOTH: r = {1'b1, v, 3'h0};
            GCR_DRV_HIZ: r = 5'h00;
            GCR_DRV_PULLUP_LO: r = v ? 5'h04 : 5'h10;
            GCR_DRV_SLOW_HI_Z: r = v ? 5'h19 : 5'h00;
            GCR_DRV_SLOW_BOTH: r = {1'b1, v, 3'h1};
            GCR_DRV_Z_SLOW_LO: r = v ? 5'h00 : 5'h11;
            default: r = 5'h00; // Reserved code: float the pin
        endcase
        return r;
    endfunction : drive_of

    // Pin index check shared by both commands
    function automatic logic idx_ok(input logic [7:0] idx);
        return idx < PIN_LIMIT;
    endfunction : idx_ok

    // Decoded command fields
    logic [7:0] cmd_type;
    logic [7:0] cmd_idx;
    logic [2:0] sel;
    logic [7:0] wr_level;
    logic [7:0] wr_cfg;
    logic wr_has_cfg;
    logic set_ok;
    logic set_cmd;
    logic read_cmd;

    assign cmd_type = addr[GCR_ADDR_TYPE_LSB +: 8];
    assign cmd_idx = addr[GCR_ADDR_IDX_LSB +: 8];
    assign sel = cmd_idx[2:0];
    assign wr_level = wdata[GCR_WD_LEVEL_LSB +: 8];
    assign wr_cfg = wdata[GCR_WD_CFG_LSB +: 8];
    assign wr_has_cfg = wdata[GCR_WD_CFG_PRESENT];

    // Validity of a set: index, level range, config range, reserved drive code
    always_comb begin
        set_ok = idx_ok(cmd_idx) && (wr_level <= GCR_LEVEL_HIGH);
        if (wr_has_cfg) begin
            set_ok = set_ok && (wr_cfg <= GCR_CFG_MAX)
                && (gcr_drive_t'(wr_cfg[2:0]) != GCR_DRV_RESERVED);
        end
    end

    gcr_state_t state_q;
    assign set_cmd = ce && wr && (cmd_type == GCR_CMD_SET) && (state_q == GCR_ST_RUN);
    assign read_cmd = ce && rd && (cmd_type == GCR_CMD_READ);

    // Per-pin stored settings
    logic [7:0] level_q [GCR_NUM_PINS];
    logic [3:0] cfg_q [GCR_NUM_PINS];

    // Boot sequencer: first enabled cycle after reset restores saved state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= GCR_ST_BOOT;
        end else if (ce) begin
            case (state_q)
                GCR_ST_BOOT: state_q <= GCR_ST_RUN;
                GCR_ST_RUN: state_q <= GCR_ST_RUN;
                default: state_q <= GCR_ST_BOOT;
            endcase
        end
    end

    // Settings storage; reset gives factory defaults, boot image overrides
    generate
        for (genvar p = 0; p < GCR_NUM_PINS; p++) begin : g_cfg
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    level_q[p] <= GCR_LEVEL_RESET;
                    cfg_q[p] <= GCR_CFG_RESET[p*4 +: 4];
                end else if (ce) begin
                    if (state_q == GCR_ST_BOOT && boot_image_valid) begin
                        level_q[p] <= boot_image_in[p*GCR_IMG_BITS +: 8];
                        cfg_q[p] <= boot_image_in[p*GCR_IMG_BITS + 8 +: 4];
                    end else if (set_cmd && set_ok && sel == 3'(p)) begin
                        level_q[p] <= wr_level;
                        if (wr_has_cfg) begin
                            cfg_q[p] <= wr_cfg[3:0];
                        end
                    end
                end
            end
        end
    endgenerate

    // Snapshot of settings for the nonvolatile store
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            boot_image_out <= '0;
            boot_image_write <= 1'b0;
        end else if (ce) begin
            boot_image_write <= boot_store && (state_q == GCR_ST_RUN);
            if (boot_store && state_q == GCR_ST_RUN) begin
                for (int p = 0; p < GCR_NUM_PINS; p++) begin
                    boot_image_out[p*GCR_IMG_BITS +: GCR_IMG_BITS] <= {cfg_q[p], level_q[p]};
                end
            end
        end
    end

    // Sample tick; free running so command timing never moves it
    logic [SW-1:0] sample_cnt_q;
    logic sample_tick;
    assign sample_tick = (sample_cnt_q == SAMPLE_LAST);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sample_cnt_q <= '0;
        end else if (ce) begin
            sample_cnt_q <= sample_tick ? '0 : sample_cnt_q + 1'b1;
        end
    end

    // Two agreeing samples in a row are needed before a level is accepted
    logic [GCR_NUM_PINS-1:0] raw_q;
    logic [GCR_NUM_PINS-1:0] stable_q;
    logic [GCR_NUM_PINS-1:0] rise_ev;
    logic [GCR_NUM_PINS-1:0] fall_ev;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            raw_q <= '0;
            stable_q <= '0;
        end else if (ce && sample_tick) begin
            raw_q <= pin_in;
            for (int p = 0; p < GCR_NUM_PINS; p++) begin
                if (pin_in[p] == raw_q[p]) begin
                    stable_q[p] <= pin_in[p];
                end
            end
        end
    end

    // Edge events on the debounced level only, so bounce never sets a flag
    always_comb begin
        for (int p = 0; p < GCR_NUM_PINS; p++) begin
            rise_ev[p] = sample_tick && (pin_in[p] == raw_q[p]) && pin_in[p] && !stable_q[p];
            fall_ev[p] = sample_tick && (pin_in[p] == raw_q[p]) && !pin_in[p] && stable_q[p];
        end
    end

    assign pin_level = stable_q;

    // Sticky edge flags; an edge in the read cycle survives the clear
    logic [GCR_NUM_PINS-1:0] rise_q;
    logic [GCR_NUM_PINS-1:0] fall_q;
    logic [GCR_NUM_PINS-1:0] flag_clr;

    always_comb begin
        for (int p = 0; p < GCR_NUM_PINS; p++) begin
            flag_clr[p] = read_cmd && idx_ok(cmd_idx) && (sel == 3'(p));
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rise_q <= '0;
            fall_q <= '0;
        end else if (ce) begin
            rise_q <= rise_ev | (rise_q & ~flag_clr);
            fall_q <= fall_ev | (fall_q & ~flag_clr);
        end
    end

    // Read answer and acknowledge, both one cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
            ack_valid <= 1'b0;
            ack_type <= '0;
        end else if (ce) begin
            rdata <= '0;
            ack_valid <= 1'b0;
            if (read_cmd) begin
                ack_valid <= 1'b1;
                if (idx_ok(cmd_idx)) begin
                    ack_type <= GCR_ACK_READ;
                    rdata[GCR_RD_IDX_LSB +: 8] <= cmd_idx;
                    rdata[GCR_RD_STAT_LSB + GCR_ST_LEVEL] <= stable_q[sel];
                    rdata[GCR_RD_STAT_LSB + GCR_ST_FALL] <= fall_q[sel];
                    rdata[GCR_RD_STAT_LSB + GCR_ST_RISE] <= rise_q[sel];
                    rdata[GCR_RD_LEVEL_LSB +: 8] <= level_q[sel];
                    rdata[GCR_RD_CFG_LSB +: 8] <= {4'h0, cfg_q[sel]};
                end else begin
                    ack_type <= GCR_ERR_FLAG | GCR_CMD_READ;
                end
            end else if (ce && wr && cmd_type == GCR_CMD_SET) begin
                ack_valid <= 1'b1;
                // Refused while restoring, when any field is out of range, or on the reserved drive code
                ack_type <= (set_cmd && set_ok) ? GCR_ACK_SET
                                                : (GCR_ERR_FLAG | GCR_CMD_SET);
            end
        end
    end

    // PWM timebase: 100 phases per period
    logic [PW-1:0] step_cnt_q;
    logic [6:0] phase_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            step_cnt_q <= '0;
            phase_q <= '0;
        end else if (ce) begin
            if (step_cnt_q == STEP_LAST) begin
                step_cnt_q <= '0;
                phase_q <= (phase_q == PHASE_LAST) ? 7'h00 : phase_q + 7'h01;
            end else begin
                step_cnt_q <= step_cnt_q + 1'b1;
            end
        end
    end

    // Pad drivers, registered so the pins never glitch on decode
    generate
        for (genvar p = 0; p < GCR_NUM_PINS; p++) begin : g_pad
            logic want;
            logic [4:0] pad;
            // Level 0 never beats the phase, 100 always does
            assign want = cfg_q[p][GCR_CFG_FUNC] ? (level_q[p] > {1'b0, phase_q})
                                                 : alt_level[p];
            assign pad = drive_of(cfg_q[p][2:0], want);

            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    pin_oe[p] <= 1'b0;
                    pin_out[p] <= 1'b0;
                    pin_pull_up[p] <= 1'b0;
                    pin_pull_down[p] <= 1'b0;
                    pin_slow[p] <= 1'b0;
                end else if (ce) begin
                    pin_oe[p] <= pad[4];
                    pin_out[p] <= pad[3];
                    pin_pull_up[p] <= pad[2];
                    pin_pull_down[p] <= pad[1];
                    pin_slow[p] <= pad[0];
                end
            end
        end
    endgenerate

endmodule : gcr_gpio
`default_nettype wire

// ### verif/gcr_gpio_sva.sv
`timescale 1ns/10ps
`default_nettype none
module gcr_gpio_sva
    import gcr_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Command port
    input wire logic [15:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic ack_valid,
    input wire logic [7:0] ack_type,
    // Boot image
    input wire logic boot_store,
    input wire logic boot_image_write
);
    logic booted_q;
    logic cmd_set;
    logic cmd_rd;
    logic cmd_any;
    logic idx_ok;
    logic set_ok;
    logic [7:0] idx;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // Sets in the boot cycle are refused, so good-set checks wait for it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            booted_q <= 1'b0;
        end else if (ce) begin
            booted_q <= 1'b1;
        end
    end
    // Request decode
    assign idx = addr[7:0];
    assign idx_ok = idx < 8'h05;
    assign cmd_set = ce && wr && addr[15:8] == GCR_CMD_SET;
    assign cmd_rd = ce && rd && addr[15:8] == GCR_CMD_READ;
    assign cmd_any = cmd_set || cmd_rd;
    assign set_ok = cmd_set && idx_ok && booted_q && wdata[7:0] <= GCR_LEVEL_HIGH
        && (!wdata[16] || (wdata[15:8] <= GCR_CFG_MAX && wdata[10:8] != 3'h6));
    a_ack_follows: assert property (cmd_any |=> ack_valid)
        else $error("no answer after command");
    a_ack_cause: assert property (ack_valid |-> $past(cmd_any))
        else $error("answer without command");
    a_set_good: assert property (set_ok |=> ack_type == GCR_ACK_SET)
        else $error("valid set not accepted");
    a_set_badidx: assert property (cmd_set && !idx_ok |=> ack_type == 8'he2)
        else $error("set to reserved pin accepted");
    a_set_badlvl: assert property (cmd_set && wdata[7:0] > GCR_LEVEL_HIGH |=> ack_type == 8'he2)
        else $error("invalid level accepted");
    a_read_echo: assert property (cmd_rd && idx_ok |=> rdata[7:0] == $past(idx))
        else $error("read answer index wrong");
    a_read_badidx: assert property (cmd_rd && !idx_ok |=> rdata == 32'h0 && ack_type == 8'he3)
        else $error("read of reserved pin answered");
    a_read_fields: assert property (cmd_rd |=> rdata[23:16] <= GCR_LEVEL_HIGH && rdata[31:28] == 4'h0)
        else $error("read level or config out of range");
    a_rdata_idle: assert property (!cmd_rd |=> rdata == 32'h0)
        else $error("read data outside answer cycle");
    a_boot_write: assert property (boot_image_write |-> $past(boot_store))
        else $error("boot image written unasked");
    // Main scenarios reached
    c_set_ok: cover property (set_ok ##1 ack_valid);
    c_read_ok: cover property (cmd_rd && idx_ok ##1 ack_type == GCR_ACK_READ);
    c_boot: cover property (boot_store ##1 boot_image_write);
endmodule : gcr_gpio_sva
bind gcr_gpio gcr_gpio_sva gcr_gpio_sva_i (.ref_clk, .rst, .ce, .addr, .wdata, .wr, .rd,
    .rdata, .ack_valid, .ack_type, .boot_store, .boot_image_write);
`default_nettype wire

// ### verif/gcr_pad_model.sv
`timescale 1ns/10ps
`default_nettype none
module gcr_pad_model
    import gcr_pkg::*;
(
    // Clock for the floating-line pattern
    input wire logic ref_clk,
    // Pad controls from the block
    input wire logic [GCR_NUM_PINS-1:0] pin_out,
    input wire logic [GCR_NUM_PINS-1:0] pin_oe,
    input wire logic [GCR_NUM_PINS-1:0] pin_pull_up,
    input wire logic [GCR_NUM_PINS-1:0] pin_pull_down,
    // Outside load standing in for a switch
    input wire logic [GCR_NUM_PINS-1:0] ext_en,
    input wire logic ext_val,
    // Level seen at the pads
    output logic [GCR_NUM_PINS-1:0] pin_in
);
    logic [GCR_NUM_PINS-1:0] float_q = '0;
    // A line nobody holds toggles, so a stale value never reads as valid
    always_ff @(posedge ref_clk) begin
        float_q <= ~float_q;
    end
    // Strong drive beats the outside load, which beats a resistive pull
    always_comb begin
        for (int p = 0; p < GCR_NUM_PINS; p++) begin
            pin_in[p] = pin_oe[p] ? pin_out[p] : ext_en[p] ? ext_val :
                pin_pull_up[p] ? 1'b1 : pin_pull_down[p] ? 1'b0 : float_q[p];
        end
    end
endmodule : gcr_pad_model
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import gcr_pkg::*;
    logic ref_clk, rst, ce, wr, rd, boot_store, ext_val, ack_valid, boot_image_write;
    logic [15:0] addr;
    logic [31:0] wdata, rdata, ack, rd_q;
    logic [7:0] ack_type;
    logic [59:0] boot_image_out;
    logic [4:0] alt_level, pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_slow;
    logic [4:0] pin_level;
    int fails, checks, cyc, n;
    localparam logic [31:0] OK_SET = {23'h0, 1'b1, GCR_ACK_SET};
    localparam logic [31:0] OK_RD = {23'h0, 1'b1, GCR_ACK_READ};
    // Pad pattern {oe,out,up,down,slow} per drive mode, level high then low
    logic [4:0] pad_hi [8] = '{5'h18, 5'h18, 5'h00, 5'h04, 5'h19, 5'h19, 5'h00, 5'h00};
    logic [4:0] pad_lo [8] = '{5'h02, 5'h10, 5'h00, 5'h10, 5'h00, 5'h11, 5'h00, 5'h11};
    // Short counts keep the PWM period and sample interval small
    gcr_gpio #(.PWM_STEP_CYCLES(2), .SAMPLE_CYCLES(8)) gcr_gpio_i (.ref_clk, .rst, .ce,
        .addr, .wdata, .wr, .rd, .rdata, .ack_valid, .ack_type, .boot_store,
        .boot_image_valid(1'b0), .boot_image_in(60'h0), .boot_image_out,
        .boot_image_write, .alt_level, .pin_level, .pin_in, .pin_out, .pin_oe,
        .pin_pull_up, .pin_pull_down, .pin_slow);
    gcr_pad_model gcr_pad_model_i (.ref_clk, .pin_out, .pin_oe, .pin_pull_up,
        .pin_pull_down, .ext_en(5'h01), .ext_val, .pin_in);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // One strobe cycle; the answer is taken in the cycle after
    task automatic cmd(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        ack = {23'h0, ack_valid, ack_type};
        rd_q = rdata;
    endtask : cmd
    task automatic set_pin(input logic [7:0] i, lv, cf, input logic p, input logic [31:0] e);
        cmd(1'b1, {GCR_CMD_SET, i}, {15'h0, p, cf, lv});
        check(ack, e);
    endtask : set_pin
    task automatic t_defaults;
        for (int p = 0; p < 5; p++) begin
            cmd(1'b0, {GCR_CMD_READ, 8'(p)}, 32'h0);
            check({8'h0, rd_q[31:16], rd_q[7:0]}, {12'h0, GCR_CFG_RESET[4*p+:4], 8'h0, 8'(p)});
            check(ack, OK_RD);
        end
        $display("defaults done");
    endtask : t_defaults
    task automatic t_modes;
        for (int m = 0; m < 8; m++) begin
            for (int v = 0; v < 2 && m != 6; v++) begin
                set_pin(8'h00, v ? 8'h64 : 8'h00, 8'(8 + m), 1'b1, OK_SET);
                @(posedge ref_clk);
                #1;
                check({pin_oe[0], pin_out[0], pin_pull_up[0], pin_pull_down[0], pin_slow[0]},
                    v ? pad_hi[m] : pad_lo[m]);
                cmd(1'b0, 16'h2300, 32'h0);
                check({16'h0, rd_q[31:16]}, {16'h0, 8'(8 + m), v ? 8'h64 : 8'h00});
            end
        end
        $display("modes done");
    endtask : t_modes
    task automatic t_pwm;
        logic [7:0] lv [3] = '{8'h01, 8'h32, 8'h63};
        for (int i = 0; i < 3; i++) begin
            set_pin(8'h01, lv[i], 8'h09, 1'b1, OK_SET);
            repeat (2) @(posedge ref_clk);
            n = 0;
            repeat (200) begin
                @(posedge ref_clk);
                #1;
                n += pin_out[1];
            end
            check(n, 2 * lv[i]);
        end
        $display("pwm done");
    endtask : t_pwm
    task automatic t_refuse;
        set_pin(8'h05, 8'h00, 8'h08, 1'b1, 32'h1e2);
        set_pin(8'h01, 8'h65, 8'h09, 1'b1, 32'h1e2);
        set_pin(8'h01, 8'h0a, 8'h10, 1'b1, 32'h1e2);
        set_pin(8'h01, 8'h0a, 8'h0e, 1'b1, 32'h1e2);
        set_pin(8'h01, 8'h1e, 8'h0f, 1'b0, OK_SET);
        cmd(1'b0, 16'h2301, 32'h0);
        check({8'h0, rd_q[31:16], rd_q[7:0]}, 32'h00091e01);
        cmd(1'b0, 16'h2305, 32'h0);
        check(rd_q, 32'h0);
        check(ack, 32'h1e3);
        $display("refuse done");
    endtask : t_refuse
    // Wait past two sample ticks, then read the status bits of pin 0
    task automatic edge_read(input logic [2:0] e);
        repeat (30) @(posedge ref_clk);
        cmd(1'b0, 16'h2300, 32'h0);
        check({29'h0, rd_q[10:8]}, {29'h0, e});
        check({31'h0, pin_level[0]}, {31'h0, e[0]});
    endtask : edge_read
    task automatic t_edges;
        set_pin(8'h00, 8'h00, 8'h0a, 1'b1, OK_SET);
        // Earlier tests may have left edges pending on pin 0; clear them first
        cmd(1'b0, 16'h2300, 32'h0);
        edge_read(3'b000);
        @(posedge ref_clk);
        ext_val <= 1'b1;
        edge_read(3'b101);
        edge_read(3'b001);
        @(posedge ref_clk);
        ext_val <= 1'b0;
        edge_read(3'b010);
        @(posedge ref_clk);
        ext_val <= 1'b1;
        repeat (3) @(posedge ref_clk);
        ext_val <= 1'b0;
        edge_read(3'b000);
        $display("edges done");
    endtask : t_edges
    task automatic t_func0;
        @(posedge ref_clk);
        alt_level <= 5'h04;
        repeat (3) @(posedge ref_clk);
        #1;
        check({30'h0, pin_oe[2], pin_out[2]}, 32'h3);
        @(posedge ref_clk);
        alt_level <= 5'h00;
        repeat (3) @(posedge ref_clk);
        #1;
        check({30'h0, pin_oe[2], pin_out[2]}, 32'h2);
        $display("default function done");
    endtask : t_func0
    task automatic t_boot;
        @(posedge ref_clk);
        boot_store <= 1'b1;
        @(posedge ref_clk);
        boot_store <= 1'b0;
        #1;
        check({31'h0, boot_image_write}, 32'h1);
        check({8'h0, boot_image_out[23:0]}, 32'h0091ea00);
        $display("boot store done");
    endtask : t_boot
    task automatic stop_test;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    // Whole run needs under a thousand cycles; a hang is cut short here
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        {rst, ce, wr, rd, boot_store, ext_val} = 6'b110000;
        addr = 16'h0;
        wdata = 32'h0;
        alt_level = 5'h00;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_defaults();
        t_modes();
        t_pwm();
        t_refuse();
        t_edges();
        t_func0();
        t_boot();
        stop_test();
    end
endmodule : testbench
`default_nettype wire
